// ### src/sspi_pkg.sv
// constants, register layout and types for the synchronous serial port core
package sspi_pkg;
	// register byte addresses on the bus
	localparam logic [7:0] OFS_BUF = 8'h00;
	localparam logic [7:0] OFS_CTL = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_ADDR = 8'h0C;
	localparam logic [7:0] OFS_IRQ = 8'h10;
	// values after reset
	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] STAT_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [3:0] SYNC_RST = 4'h3;
	// operating modes of the four-bit select
	localparam logic [3:0] MODE_SPI_M = 4'h0;
	localparam logic [3:0] MODE_SPI_S = 4'h4;
	localparam logic [3:0] MODE_I2C_S7 = 4'h6;
	localparam logic [3:0] MODE_I2C_S10 = 4'h7;
	localparam logic [3:0] MODE_I2C_M = 4'h8;
	// timing: glitch filter span and four-wire master half period
	localparam int CLK_MHZ = 40;
	localparam int FILT_NS = 50;
	localparam logic [2:0] FILT_CYC = 3'((FILT_NS * CLK_MHZ + 999) / 1000);
	localparam logic [8:0] SPI_HALF_LIM = 9'h001;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// first control register layout
	typedef struct packed {
		logic write_collision_flag;
		logic ov;
		logic en;
		logic clock_polarity_bit;
		logic [3:0] mode;
	} ctl_t;
	// status register layout
	typedef struct packed {
		logic sample_phase_bit;
		logic cke;
		logic da;
		logic stop;
		logic start;
		logic rw;
		logic ua;
		logic bf;
	} stat_t;
	// engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_SHIFT = 3'h2,
		ST_ACK = 3'h4
	} state_t;
endpackage : sspi_pkg

// ### src/sspi_core.sv
// synchronous serial port core: four-wire and two-wire engine with its register file
//
// Functional notes
// [R1] four-wire master freezes during sleep, then resumes
// [R2] four-wire slave shifts on link clock, sleeping too
// [R3] completed slave byte sets flag, wakes if enabled
// [R4] reset disables port, zeroes control and status
// [R5] control: collision, overflow, enable, polarity, mode
// [R6] modes: slave 7-bit, slave 10-bit, master
// [R7] master clock is osc/4 over reload plus one
// [R8] start and stop detected, flagged, raise interrupt
// [R9] glitch filter on both bus inputs
// [R10] software makes both bus lines inputs first
// [R11] enable in two-wire mode takes over pins
// [R12] status shows start/stop, data/address, update, direction
// [R13] shifter reachable only through the buffer
// [R14] full byte copied to buffer, flag set
// [R15] byte before buffer read: overflow, byte lost
// [R16] 10-bit: software loads high pattern first
// [R17] after high match software loads low byte
// [R18] slave compares upper seven received bits
// [R19] no acknowledge when buffer full or overflow
// [R20] reading the buffer clears buffer full
// [R21] overflow stays until software clears it
`timescale 1ns/1ps
module sspi_core
	import sspi_pkg::*;
#(
	parameter logic [2:0] FILT_LEN = FILT_CYC
)(
	input logic CLK_SYS,
	input logic RST,
	input logic CE,
	input logic SLEEP,
	input logic PSEL,
	input logic PENABLE,
	input logic PWRITE,
	input logic [7:0] PADDR,
	input logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE,
	input logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input logic SCK_I,
	output logic SCK_O,
	output logic SCK_OE,
	input logic SDI,
	output logic SDO,
	output logic SDO_OE,
	output logic WAKE
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	ctl_t ctl; // first control register
	stat_t st; // status register
	logic [7:0] addr; // address / reload register
	logic [7:0] buf_q; // transfer buffer
	logic irq; // port interrupt flag
	logic ie; // port interrupt enable
	state_t state; // engine state
	logic [3:0] bitcnt; // bits shifted in this byte
	logic [7:0] sh; // internal shifter, never on the bus
	logic out_bit; // bit driven by two-wire master
	logic ack_drv; // slave pulls data low for acknowledge
	logic want_addr; // next byte is an address
	logic want_lo; // next byte is 10-bit low address
	logic ev_byte; // byte complete pulse
	logic ev_addr; // that byte was an address
	logic ev_ua; // that byte asks for an address update
	logic ev_rwv; // direction to report
	logic [3:0] pin_a; // first sync stage, read by pin_b only
	logic [3:0] pin_b; // synced pins: sdi, sck, sda, scl
	logic [1:0] line_f; // filtered scl, sda
	logic scl_p, sda_p, lv_p; // previous levels
	logic gen_clk; // generated master clock, idle low
	logic [8:0] gen_cnt; // divider count
	logic [8:0] gen_lim; // divider terminal count
	logic spim, spis, spi, i2cs7, i2cs10, i2cs, i2cm, i2c;
	logic frz, busy, lv, rise, fall, start_ev, stop_ev, hit;
	logic wr, rd, buf_wr, mapped;
	logic [7:0] rdata;

	////////////////////////////////////////////////////////////////////////////////
	// mode decode, only while the port is enabled
	assign spim = ctl.en && (ctl.mode == MODE_SPI_M); // see [R6]
	assign spis = ctl.en && (ctl.mode == MODE_SPI_S);
	assign i2cs7 = ctl.en && (ctl.mode == MODE_I2C_S7); // see [R6]
	assign i2cs10 = ctl.en && (ctl.mode == MODE_I2C_S10); // see [R6]
	assign i2cm = ctl.en && (ctl.mode == MODE_I2C_M); // see [R6]
	assign spi = spim || spis;
	assign i2cs = i2cs7 || i2cs10;
	assign i2c = i2cs || i2cm;
	// four-wire master stalls while asleep; slave keeps running
	assign frz = spim && SLEEP; // see [R1]
	assign busy = (spim || i2cm) ? (state != ST_IDLE) : (bitcnt != 4'h0);

	////////////////////////////////////////////////////////////////////////////////
	// bus decode; PREADY follows CE so a frozen core stretches the access
	assign wr = PSEL && PENABLE && PWRITE && CE;
	assign rd = PSEL && PENABLE && !PWRITE && CE;
	assign buf_wr = wr && (PADDR == OFS_BUF);
	assign PREADY = CE;
	assign mapped = (PADDR == OFS_BUF) || (PADDR == OFS_CTL) || (PADDR == OFS_STAT)
		|| (PADDR == OFS_ADDR) || (PADDR == OFS_IRQ);
	assign PSLVERR = PSEL && PENABLE && !mapped;

	////////////////////////////////////////////////////////////////////////////////
	// two-stage sync of every pin input
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			pin_a <= SYNC_RST;
			pin_b <= SYNC_RST;
		end else if (CE) begin
			pin_a <= {SDI, SCK_I, SDA_I, SCL_I};
			pin_b <= pin_a;
		end
	end

	// spike filter: a new level must hold FILT_LEN cycles before it counts
	for (genvar gi = 0; gi < 2; gi++) begin : g_filt
		logic [2:0] run; // cycles the raw level has differed
		logic lvl; // accepted level
		always_ff @(posedge CLK_SYS) begin
			if (RST) begin
				run <= 3'h0;
				lvl <= 1'b1;
			end else if (CE) begin
				if (pin_b[gi] == lvl) begin
					run <= 3'h0;
				end else if (run >= FILT_LEN - 3'h1) begin // see [R9]
					run <= 3'h0;
					lvl <= pin_b[gi];
				end else begin
					run <= run + 3'h1;
				end
			end
		end
		assign line_f[gi] = lvl;
	end

	// previous levels for edge and condition detection
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			lv_p <= 1'b0;
		end else if (CE && !frz) begin
			scl_p <= line_f[0];
			sda_p <= line_f[1];
			lv_p <= lv;
		end
	end

	// shift clock: generated for masters, sampled link clock for four-wire slave
	assign lv = (spim || i2cm) ? gen_clk : (spis ? (pin_b[2] ^ ctl.clock_polarity_bit) : line_f[0]); // see [R2]
	assign rise = lv && !lv_p;
	assign fall = !lv && lv_p;
	// data moving while clock high marks start or stop
	assign start_ev = i2c && line_f[0] && scl_p && sda_p && !line_f[1]; // see [R8]
	assign stop_ev = i2c && line_f[0] && scl_p && !sda_p && line_f[1]; // see [R8]

	////////////////////////////////////////////////////////////////////////////////
	// master clock divider; no clock stretching seen from the bus
	assign gen_lim = spim ? SPI_HALF_LIM : {addr, 1'b1}; // see [R7]
	always_ff @(posedge CLK_SYS) begin
		if (RST || !(spim || i2cm) || (state == ST_IDLE)) begin
			gen_cnt <= 9'h000;
			gen_clk <= 1'b0;
		end else if (CE && !frz) begin // see [R1]
			if (gen_cnt >= gen_lim) begin
				gen_cnt <= 9'h000;
				gen_clk <= !gen_clk;
			end else begin
				gen_cnt <= gen_cnt + 9'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// address match, upper seven bits or full low byte
	assign hit = i2cm || (want_lo ? (sh == addr) // see [R17]
		: (want_addr ? (sh[7:1] == addr[7:1]) : 1'b1)); // see [R18] see [R16]

	// shift engine
	always_ff @(posedge CLK_SYS) begin
		if (RST || !ctl.en) begin // see [R4]
			state <= ST_IDLE;
			bitcnt <= 4'h0;
			sh <= 8'h00;
			out_bit <= 1'b1;
			ack_drv <= 1'b0;
			want_addr <= 1'b0;
			want_lo <= 1'b0;
			ev_byte <= 1'b0;
			ev_addr <= 1'b0;
			ev_ua <= 1'b0;
			ev_rwv <= 1'b0;
		end else if (CE && !frz) begin // see [R1]
			ev_byte <= 1'b0;
			if (buf_wr && !busy) begin
				// software reaches the shifter only through a buffer write
				sh <= PWDATA[7:0]; // see [R13]
				out_bit <= PWDATA[7];
				bitcnt <= 4'h0;
				if (spim || i2cm) begin
					state <= ST_SHIFT;
				end
			end else if (i2cs && start_ev) begin
				state <= ST_SHIFT;
				bitcnt <= 4'h0;
				want_addr <= 1'b1;
				want_lo <= 1'b0;
				ack_drv <= 1'b0;
			end else if (i2cs && stop_ev) begin
				state <= ST_IDLE;
				// a stop ends any partial byte, else the port would look busy
				bitcnt <= 4'h0;
				ack_drv <= 1'b0;
			end else if (spi) begin
				if (rise && (bitcnt != BYTE_BITS)) begin
					sh <= {sh[6:0], pin_b[3]}; // see [R2]
					bitcnt <= bitcnt + 4'h1;
					ev_byte <= (bitcnt == BYTE_BITS - 4'h1); // see [R3]
					ev_addr <= 1'b0;
					ev_ua <= 1'b0;
				end else if (fall && (bitcnt == BYTE_BITS)) begin
					bitcnt <= 4'h0;
					state <= ST_IDLE;
				end
			end else if (i2c) begin
				case (state)
					ST_SHIFT: begin
						if (rise && (bitcnt != BYTE_BITS)) begin
							sh <= {sh[6:0], line_f[1]};
							bitcnt <= bitcnt + 4'h1;
						end else if (fall && (bitcnt == BYTE_BITS)) begin
							ev_byte <= hit;
							ev_addr <= want_addr || want_lo;
							ev_ua <= i2cs10 && (want_addr || want_lo);
							ev_rwv <= want_addr ? sh[0] : st.rw;
							ack_drv <= i2cs && hit && !st.bf && !ctl.ov; // see [R19]
							state <= hit ? ST_ACK : ST_IDLE;
							if (hit) begin
								want_addr <= 1'b0;
								want_lo <= i2cs10 && want_addr && !sh[0];
							end
						end else if (fall) begin
							// change data only while the clock is low
							out_bit <= sh[7];
						end
					end
					ST_ACK: begin
						if (fall) begin
							ack_drv <= 1'b0;
							bitcnt <= 4'h0;
							state <= i2cs ? ST_SHIFT : ST_IDLE;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register file; hardware sets come last so they win over clears
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin // see [R4]
			ctl <= ctl_t'(CTL_RST);
			st <= stat_t'(STAT_RST);
			addr <= ADDR_RST;
			buf_q <= 8'h00;
			irq <= 1'b0;
			ie <= 1'b0;
		end else if (CE) begin
			if (wr && (PADDR == OFS_CTL)) begin
				ctl <= ctl_t'(PWDATA[7:0]); // see [R5] see [R21]
			end
			if (wr && (PADDR == OFS_STAT)) begin
				st.sample_phase_bit <= PWDATA[7];
				st.cke <= PWDATA[6];
			end
			if (wr && (PADDR == OFS_ADDR)) begin
				addr <= PWDATA[7:0];
				st.ua <= 1'b0;
			end
			if (wr && (PADDR == OFS_IRQ)) begin
				irq <= PWDATA[0];
				ie <= PWDATA[1];
			end
			if (buf_wr) begin
				if (busy) begin
					ctl.write_collision_flag <= 1'b1; // write dropped mid transfer
				end else begin
					buf_q <= PWDATA[7:0];
				end
			end
			if (rd && (PADDR == OFS_BUF)) begin
				st.bf <= 1'b0; // see [R20]
			end
			if (ev_byte) begin
				irq <= 1'b1; // see [R3] see [R14]
				if (st.bf) begin
					ctl.ov <= 1'b1; // see [R15]
				end else begin
					buf_q <= sh; // see [R14]
					st.bf <= 1'b1;
				end
				st.da <= !ev_addr; // see [R12]
				if (ev_addr) begin
					st.rw <= ev_rwv;
				end
				if (ev_ua) begin
					st.ua <= 1'b1;
				end
			end
			if (start_ev) begin
				st.start <= 1'b1; // see [R8]
				st.stop <= 1'b0;
				irq <= 1'b1;
			end
			if (stop_ev) begin
				st.stop <= 1'b1; // see [R8]
				st.start <= 1'b0;
				irq <= 1'b1;
			end
			if (!ctl.en) begin
				st.start <= 1'b0;
				st.stop <= 1'b0;
			end
		end
	end

	// read mux; the shifter has no address
	always_comb begin
		case (PADDR)
			OFS_BUF: rdata = buf_q; // see [R13]
			OFS_CTL: rdata = ctl;
			OFS_STAT: rdata = {st.sample_phase_bit, st.cke, st.da, st.stop, st.start,
				i2cm ? busy : st.rw, st.ua, st.bf}; // see [R12]
			OFS_ADDR: rdata = addr;
			OFS_IRQ: rdata = {6'h00, ie, irq};
			default: rdata = 8'h00;
		endcase
	end

	// read data captured in the setup phase, one cycle before it is sampled
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			PRDATA <= 32'h00000000;
		end else if (CE && PSEL && !PENABLE) begin
			PRDATA <= {24'h000000, rdata};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pins; bus lines are driven only low, and only in two-wire modes
	assign SCL_O = 1'b0;
	assign SDA_O = 1'b0;
	assign SCL_OE = i2cm && (state != ST_IDLE) && !gen_clk; // see [R11] see [R10]
	assign SDA_OE = ack_drv || (i2cm && (state == ST_SHIFT) && !out_bit); // see [R11]
	assign SCK_O = gen_clk ^ ctl.clock_polarity_bit;
	assign SCK_OE = spim;
	assign SDO = sh[7];
	assign SDO_OE = spi;
	assign WAKE = irq && ie; // see [R3]

	////////////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);

	property p_reset;
		disable iff (1'b0) RST |=> (ctl == CTL_RST) && (st == STAT_RST) && !irq;
	endproperty
	a_reset: assert property (p_reset) else $error("reset left state"); // see [R4]

	property p_fill;
		CE && ev_byte && !st.bf |=> st.bf && (buf_q == $past(sh)) && irq;
	endproperty
	a_fill: assert property (p_fill) else $error("byte not buffered"); // see [R14]

	property p_over;
		CE && ev_byte && st.bf && !buf_wr |=> ctl.ov && $stable(buf_q);
	endproperty
	a_over: assert property (p_over) else $error("overflow missed"); // see [R15]

	property p_ovkeep;
		CE && ctl.ov && !(wr && (PADDR == OFS_CTL)) |=> ctl.ov;
	endproperty
	a_ovkeep: assert property (p_ovkeep) else $error("overflow lost"); // see [R21]

	property p_rdclr;
		CE && rd && (PADDR == OFS_BUF) && !ev_byte |=> !st.bf;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("full kept after read"); // see [R20]

	property p_ack;
		$rose(ack_drv) |-> $past(!st.bf && !ctl.ov);
	endproperty
	a_ack: assert property (p_ack) else $error("ack while full"); // see [R19]

	property p_freeze;
		frz && CE && ctl.en |=> $stable(sh) && $stable(bitcnt) && $stable(gen_clk);
	endproperty
	a_freeze: assert property (p_freeze) else $error("moved in sleep"); // see [R1]

	property p_oe;
		SCL_OE || SDA_OE |-> i2c;
	endproperty
	a_oe: assert property (p_oe) else $error("bus driven off mode"); // see [R11]

	property p_start;
		CE && start_ev |=> st.start && !st.stop && irq;
	endproperty
	a_start: assert property (p_start) else $error("start not flagged"); // see [R8]

	property p_miss;
		CE && i2cs && (state == ST_SHIFT) && fall && (bitcnt == BYTE_BITS) && want_addr
			&& !want_lo && (sh[7:1] != addr[7:1]) && !buf_wr && !start_ev && !stop_ev
			|=> (state == ST_IDLE) && !ev_byte && !ack_drv;
	endproperty
	a_miss: assert property (p_miss) else $error("foreign address taken"); // see [R18]

	c_spi: cover property (CE && ev_byte && spi);
	c_ack: cover property ($rose(ack_drv));
	c_ov: cover property ($rose(ctl.ov));

endmodule : sspi_core

// ### test/bus_master_model.sv
// external two-wire bus master that only ever pulls the lines low
`timescale 1ns/1ps
module bus_master_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low
);
	// eight times the minimum high and low time the port asks for
	localparam int HALF = 16;
	// both lines released at time zero, the pull-ups win
	initial begin
		scl_low = 1'h0;
		sda_low = 1'h0;
	end
	task automatic hold;
		repeat (HALF) @(posedge clk);
	endtask : hold
	// data falls while the clock line stays high
	task automatic start_cond;
		sda_low <= 1'h1;
		hold();
		scl_low <= 1'h1;
		hold();
	endtask : start_cond
	// one-cycle dip on the data line while the clock line is high
	task automatic glitch;
		sda_low <= 1'h1;
		@(posedge clk);
		sda_low <= 1'h0;
		hold();
	endtask : glitch
	// data rises while the clock line stays high
	task automatic stop_cond;
		sda_low <= 1'h1;
		hold();
		scl_low <= 1'h0;
		hold();
		sda_low <= 1'h0;
		hold();
	endtask : stop_cond
	// eight bits msb first, then a ninth clock with data released
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_low <= !b[i];
			hold();
			scl_low <= 1'h0;
			hold();
			scl_low <= 1'h1;
		end
		sda_low <= 1'h0;
		hold();
		scl_low <= 1'h0;
		repeat (HALF / 2) @(posedge clk);
		// a low line mid-pulse means the port acknowledged
		ack = !sda;
		repeat (HALF / 2) @(posedge clk);
		scl_low <= 1'h1;
		hold();
	endtask : send_byte
endmodule : bus_master_model

// ### test/tb.sv
// bench: registers, two-wire slave traffic, master clock, sleep cases, reset
`timescale 1ns/1ps
module tb;
	import sspi_pkg::*;
	logic clk_sys = 1'h0, rst = 1'h1, sleep = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, sck_o, sck_oe, sdo, sdo_oe, wake;
	logic sck_i = 1'h0, sdi = 1'h0, m_scl_low, m_sda_low, ack, err;
	// open drain with pull-ups, nobody drives the lines high
	wire scl_line = !(scl_oe | m_scl_low);
	wire sda_line = !(sda_oe | m_sda_low);
	int fails = 0, num_checks = 0, cycles = 0;
	ctl_t c;
	stat_t s;
	realtime t0;
	always #12.5 clk_sys = ~clk_sys;
	sspi_core dut (.CLK_SYS(clk_sys), .RST(rst), .CE(1'h1), .SLEEP(sleep), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SCL_I(scl_line), .SCL_O(scl_o), .SCL_OE(scl_oe),
		.SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE(sda_oe), .SCK_I(sck_i), .SCK_O(sck_o),
		.SCK_OE(sck_oe), .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .WAKE(wake));
	bus_master_model mst (.clk(clk_sys), .sda(sda_line), .scl_low(m_scl_low),
		.sda_low(m_sda_low));
	////////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask : chk
	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'h1;
		@(posedge clk_sys);
		while (pready !== 1'h1) @(posedge clk_sys);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
		apb(1'h0, a, 8'h00);
		chk(what, {24'h000000, exp}, q);
	endtask : rd
	task automatic stat_rd;
		apb(1'h0, OFS_STAT, 8'h00);
		s = q[7:0];
	endtask : stat_rd
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : ticks
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd("ctl", OFS_CTL, CTL_RST);
		rd("status", OFS_STAT, STAT_RST);
		rd("addr", OFS_ADDR, ADDR_RST);
		rd("irq", OFS_IRQ, 8'h00);
		rd("unmapped", 8'h14, 8'h00);
		chk("slverr", 32'h1, err);
		apb(1'h1, OFS_CTL, 8'hD5);
		rd("ctl bits", OFS_CTL, 8'hD5);
		apb(1'h1, OFS_CTL, 8'h00);
	endtask : t_regs
	// address hit, full buffer, overflow, stop, then an address miss
	task automatic t_slave7;
		c = '{write_collision_flag: 1'h0, ov: 1'h0, en: 1'h1, clock_polarity_bit: 1'h0, mode: MODE_I2C_S7};
		apb(1'h1, OFS_ADDR, 8'h84);
		apb(1'h1, OFS_CTL, c);
		// a one-cycle dip with the clock high must not read as a start
		mst.glitch();
		stat_rd();
		chk("glitch start", 32'h0, s.start);
		mst.start_cond();
		mst.send_byte(8'h84, ack);
		chk("ack hit", 32'h1, ack);
		rd("status addr", OFS_STAT, 8'h09);
		rd("irq byte", OFS_IRQ, 8'h01);
		mst.send_byte(8'h5A, ack);
		chk("ack full", 32'h0, ack);
		c.ov = 1'h1;
		rd("ctl ov", OFS_CTL, c);
		rd("buf kept", OFS_BUF, 8'h84);
		stat_rd();
		chk("bf read", 32'h0, s.bf);
		rd("ov kept", OFS_CTL, c);
		mst.send_byte(8'hC3, ack);
		chk("ack ov", 32'h0, ack);
		rd("buf ov", OFS_BUF, 8'hC3);
		apb(1'h1, OFS_IRQ, 8'h02);
		ticks(1);
		chk("wake off", 32'h0, wake);
		mst.stop_cond();
		stat_rd();
		chk("stop", 32'h1, s.stop);
		chk("start", 32'h0, s.start);
		chk("wake stop", 32'h1, wake);
		c.ov = 1'h0;
		apb(1'h1, OFS_CTL, c);
		mst.start_cond();
		mst.send_byte(8'h86, ack);
		chk("ack miss", 32'h0, ack);
		mst.stop_cond();
	endtask : t_slave7
	task automatic t_slave10;
		c.mode = MODE_I2C_S10;
		apb(1'h1, OFS_ADDR, 8'hF2);
		apb(1'h1, OFS_CTL, c);
		mst.start_cond();
		mst.send_byte(8'hF2, ack);
		chk("ack high", 32'h1, ack);
		stat_rd();
		chk("ua", 32'h1, s.ua);
		apb(1'h1, OFS_ADDR, 8'h35);
		apb(1'h0, OFS_BUF, 8'h00);
		mst.send_byte(8'h35, ack);
		chk("ack low", 32'h1, ack);
		mst.stop_cond();
		rd("buf low", OFS_BUF, 8'h35);
	endtask : t_slave10
	// bus clock period with reload 2 is four times three cycles
	task automatic t_mclk;
		c.mode = MODE_I2C_M;
		apb(1'h1, OFS_ADDR, 8'h02);
		apb(1'h1, OFS_CTL, c);
		apb(1'h1, OFS_BUF, 8'hFF);
		@(posedge scl_oe);
		t0 = $realtime;
		@(posedge scl_oe);
		chk("scl period", 32'd12, int'(($realtime - t0) / 25.0));
		apb(1'h1, OFS_CTL, 8'h00);
	endtask : t_mclk
	// slave shifts a byte while asleep and wakes the processor
	task automatic t_spi_slave;
		logic [7:0] b;
		b = 8'hA7;
		c.mode = MODE_SPI_S;
		apb(1'h1, OFS_CTL, c);
		apb(1'h1, OFS_IRQ, 8'h02);
		sleep <= 1'h1;
		for (int i = 7; i >= 0; i--) begin
			sdi <= b[i];
			ticks(6);
			sck_i <= 1'h1;
			ticks(6);
			sck_i <= 1'h0;
		end
		sdi <= ~b[0];
		ticks(12);
		chk("wake", 32'h1, wake);
		sleep <= 1'h0;
		rd("spi buf", OFS_BUF, b);
	endtask : t_spi_slave
	// master clock stands still in sleep, byte completes after wake
	task automatic t_spi_master;
		logic held;
		c.mode = MODE_SPI_M;
		// data line held high so every sampled bit of the byte is one
		sdi <= 1'h1;
		apb(1'h1, OFS_CTL, c);
		apb(1'h1, OFS_BUF, 8'h3C);
		chk("sck oe", 32'h1, sck_oe);
		chk("sdo oe", 32'h1, sdo_oe);
		ticks(3);
		sleep <= 1'h1;
		ticks(2);
		held = sck_o;
		// eleven half link periods, so a running clock would show inverted
		ticks(22);
		chk("sck frozen", held, sck_o);
		stat_rd();
		chk("bf asleep", 32'h0, s.bf);
		// a buffer write while the byte is parked must collide
		apb(1'h1, OFS_BUF, 8'h55);
		rd("write_collision_flag", OFS_CTL, 8'hA0);
		sleep <= 1'h0;
		ticks(60);
		stat_rd();
		chk("bf resumed", 32'h1, s.bf);
		chk("sdo msb", 32'h1, sdo);
		rd("spi rx", OFS_BUF, 8'hFF);
		rst <= 1'h1;
		ticks(2);
		rst <= 1'h0;
		rd("ctl reset", OFS_CTL, 8'h00);
		rd("status reset", OFS_STAT, 8'h00);
		chk("sck oe reset", 32'h0, sck_oe);
	endtask : t_spi_master
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			report_and_stop();
		end
	end
	initial begin
		ticks(6);
		rst <= 1'h0;
		t_regs();
		t_slave7();
		t_slave10();
		t_mclk();
		t_spi_slave();
		t_spi_master();
		report_and_stop();
	end
endmodule : tb
